// [common/csfl_pkg.sv]
// constants for the status flag and workspace context block
// assumes a 16-bit word machine with byte addressing of memory
package csfl_pkg;
	// status word flag positions (our layout; no figure fixes them)
	localparam int FL_LGT = 15;
	localparam int FL_AGT = 14;
	localparam int FL_EQ = 13;
	localparam int FL_C = 12;
	localparam int FL_OV = 11;
	localparam int FL_OP = 10;
	localparam int FL_X = 9;
	localparam logic [15:0] FLAG_MASK = 16'hfe00;
	localparam logic [15:0] MOST_NEG = 16'h8000;
	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [15:0] WS_WORDS = 16'h0010;
	localparam logic [15:0] ST_RESET = 16'h0000;
	localparam logic [15:0] WP_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// operation codes
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_CMP = 4'h1;
	localparam logic [3:0] OP_ADD = 4'h2;
	localparam logic [3:0] OP_SUB = 4'h3;
	localparam logic [3:0] OP_SLA = 4'h4;
	localparam logic [3:0] OP_SRL = 4'h5;
	localparam logic [3:0] OP_DIV = 4'h6;
	localparam logic [3:0] OP_ABS = 4'h7;
	localparam logic [3:0] OP_NEG = 4'h8;
	localparam logic [3:0] OP_XOP = 4'h9;
	localparam logic [3:0] OP_MOV = 4'ha;
	// wishbone register offsets (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPA = 8'h04;
	localparam logic [7:0] A_OPB = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0c;
	localparam logic [7:0] A_RESULT = 8'h10;
	localparam logic [7:0] A_WP = 8'h14;
	localparam logic [7:0] A_PC = 8'h18;
	localparam logic [7:0] A_SAVE = 8'h1c;
	localparam logic [7:0] A_IRQ_ST = 8'h20;
	localparam logic [7:0] A_IRQ_MASK = 8'h24;
	localparam logic [7:0] A_REGADDR = 8'h28;
	localparam logic [7:0] A_DIVHI = 8'h2c;
	// ctrl fields
	localparam int C_OP_LSB = 0;
	localparam int C_BYTE = 4;
	localparam int C_SHCNT_LSB = 8;
	localparam int C_REG_LSB = 12;
	localparam int C_START = 16;
	localparam int C_CTXSW = 17;
	localparam int C_FETCH = 18;
	localparam int C_AFF_LSB = 20;
	// interrupt events
	localparam int EV_DONE = 0;
	localparam int EV_OV = 1;
	localparam int EV_XOP = 2;
	localparam int EV_CTX = 3;
	localparam int EV_N = 4;
endpackage

// [core/csfl_alu.sv]
// combinational flag datapath for one operation
// assumes operands stable while op_i is presented
module csfl_alu (
	input wire logic [3:0] op_i, // operation code
	input wire logic byte_i, // byte operation
	input wire logic [15:0] a_i, // source operand
	input wire logic [15:0] b_i, // destination operand
	input wire logic [15:0] div_hi_i, // dividend upper half
	input wire logic [3:0] shcnt_i, // shift count, 0 means 16
	output logic [15:0] res_o, // result
	output logic [15:0] flags_o // computed flags
);
	logic [16:0] sum;
	logic [15:0] sa;
	logic [15:0] sb;
	logic [15:0] rr;
	logic [15:0] fl;
	logic [4:0] cnt;
	logic [31:0] sh;
	logic sgn_chg;
	logic last_out;
	always_comb begin
		sa = byte_i ? {a_i[15:8], 8'h00} : a_i;
		sb = byte_i ? {b_i[15:8], 8'h00} : b_i;
		fl = 16'h0000;
		rr = 16'h0000;
		sum = 17'h00000;
		sh = 32'h00000000;
		sgn_chg = 1'b0;
		last_out = 1'b0;
		cnt = (shcnt_i == 4'h0) ? 5'h10 : {1'b0, shcnt_i};
		case (op_i)
			csfl_pkg::OP_ADD: begin
				sum = {1'b0, sb} + {1'b0, sa};
				rr = sum[15:0];
				fl[csfl_pkg::FL_C] = sum[16];
				fl[csfl_pkg::FL_OV] = (sa[15] == sb[15]) && (rr[15] != sb[15]);
			end
			csfl_pkg::OP_SUB: begin
				sum = {1'b0, sb} + {1'b0, ~sa} + 17'h00001;
				rr = sum[15:0];
				fl[csfl_pkg::FL_C] = sum[16];
				fl[csfl_pkg::FL_OV] = (sa[15] != sb[15]) && (rr[15] != sb[15]);
			end
			csfl_pkg::OP_SLA: begin
				sh = {16'h0000, a_i} << cnt;
				rr = sh[15:0];
				fl[csfl_pkg::FL_C] = sh[16];
				for (int i = 1; i <= 15; i++) begin
					if (i <= int'(cnt) && a_i[15 - i] != a_i[15])
						sgn_chg = 1'b1;
				end
				// the sixteenth step shifts a zero into the sign
				if (cnt == 5'h10 && a_i[15])
					sgn_chg = 1'b1;
				fl[csfl_pkg::FL_OV] = sgn_chg;
			end
			csfl_pkg::OP_SRL: begin
				sh = {a_i, 16'h0000} >> cnt;
				rr = sh[31:16];
				last_out = sh[15];
				fl[csfl_pkg::FL_C] = last_out;
			end
			csfl_pkg::OP_DIV: begin
				fl[csfl_pkg::FL_OV] = div_hi_i >= a_i;
				rr = div_hi_i;
			end
			csfl_pkg::OP_ABS: begin
				rr = a_i[15] ? 16'(~a_i + 16'h0001) : a_i;
				fl[csfl_pkg::FL_OV] = a_i == csfl_pkg::MOST_NEG;
			end
			csfl_pkg::OP_NEG: begin
				rr = 16'(~a_i + 16'h0001);
				fl[csfl_pkg::FL_OV] = a_i == csfl_pkg::MOST_NEG;
			end
			csfl_pkg::OP_XOP: begin
				fl[csfl_pkg::FL_X] = 1'b1;
			end
			default: rr = sa;
		endcase
		if (op_i == csfl_pkg::OP_CMP) begin
			fl[csfl_pkg::FL_EQ] = sa == sb;
			fl[csfl_pkg::FL_LGT] = sa > sb;
			fl[csfl_pkg::FL_AGT] = $signed(sa) > $signed(sb);
		end else begin
			fl[csfl_pkg::FL_EQ] = (byte_i ? {rr[15:8], 8'h00} : rr) == 16'h0000;
			fl[csfl_pkg::FL_LGT] = rr != 16'h0000;
			fl[csfl_pkg::FL_AGT] = !rr[15] && rr != 16'h0000;
		end
		if (byte_i)
			fl[csfl_pkg::FL_OP] = ^(op_i == csfl_pkg::OP_CMP ? sa[15:8] : rr[15:8]);
		res_o = rr;
		flags_o = fl;
	end
endmodule

// [core/csfl_ctx.sv]
// context save store: workspace pointer, program counter, status word
// assumes save and restore never asserted together
module csfl_ctx (
	input wire logic clk_i, // clock
	input wire logic rst_i, // sync reset
	input wire logic ce_i, // clock enable
	input wire logic save_i, // capture context
	input wire logic [15:0] wp_i, // live pointer
	input wire logic [15:0] pc_i, // live counter
	input wire logic [15:0] st_i, // live status word
	output logic [47:0] saved_o // saved wp, pc, st
);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			saved_o <= 48'h000000000000;
		else if (ce_i && save_i)
			saved_o <= {wp_i, pc_i, st_i};
	end
	a_ctx_saved: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && save_i |=> saved_o == {$past(wp_i), $past(pc_i), $past(st_i)})
		else $error("context not saved");
endmodule

// [core/csfl_top.sv]
// status flag generation and workspace context block with wishbone slave
// assumes a classic wishbone master on clk_i, 32-bit data
//
// Implementation choices: the address map and the Wishbone slave port.
module csfl_top (
	input wire logic clk_i, // clock, 25 MHz
	input wire logic rst_i, // sync reset, active high
	input wire logic ce_i, // clock enable
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic irq_o // level interrupt
);
	logic [15:0] opa;
	logic [15:0] opb;
	logic [15:0] div_hi;
	logic [15:0] status_word;
	logic [15:0] result;
	logic [15:0] wp;
	logic [15:0] pc;
	logic [15:0] ws_addr;
	logic [31:0] ctrl;
	logic [csfl_pkg::EV_N-1:0] irq_st;
	logic [csfl_pkg::EV_N-1:0] irq_mask;
	logic [csfl_pkg::EV_N-1:0] ev;
	logic [15:0] alu_res;
	logic [15:0] alu_fl;
	logic [15:0] aff;
	logic [47:0] saved;
	logic [3:0] op;
	logic req;
	logic wr;
	logic rd;
	logic wr_ctrl;
	logic start;
	logic ctxsw;
	logic fetch;
	logic [15:0] next_status;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = ce_i && req && wb_we_i;
	assign rd = ce_i && req && !wb_we_i;
	assign wr_ctrl = wr && wb_adr_i == csfl_pkg::A_CTRL;
	assign start = wr_ctrl && wb_dat_i[csfl_pkg::C_START];
	assign ctxsw = wr_ctrl && wb_dat_i[csfl_pkg::C_CTXSW];
	assign fetch = wr_ctrl && wb_dat_i[csfl_pkg::C_FETCH];
	assign op = ctrl[csfl_pkg::C_OP_LSB +: 4];

	csfl_alu csfl_alu_inst (
		.op_i(op),
		.byte_i(ctrl[csfl_pkg::C_BYTE]),
		.a_i(opa),
		.b_i(opb),
		.div_hi_i(div_hi),
		.shcnt_i(ctrl[csfl_pkg::C_SHCNT_LSB +: 4]),
		.res_o(alu_res),
		.flags_o(alu_fl)
	);

	csfl_ctx csfl_ctx_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.save_i(ctxsw),
		.wp_i(wp),
		.pc_i(pc),
		.st_i(status_word),
		.saved_o(saved)
	);

	// one-cycle ack, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else if (ce_i)
			wb_ack_o <= req;
	end

	// byte-laned register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int k = 0; k < 4; k++) begin
			if (sel[k])
				m[8*k +: 8] = d[8*k +: 8];
		end
		return m;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= 32'h00000000;
			opa <= 16'h0000;
			opb <= 16'h0000;
			div_hi <= 16'h0000;
			irq_mask <= '0;
		end else if (wr) begin
			case (wb_adr_i)
				csfl_pkg::A_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'hfff0ffff;
				csfl_pkg::A_OPA: opa <= 16'(merge({16'h0000, opa}, wb_dat_i, wb_sel_i));
				csfl_pkg::A_OPB: opb <= 16'(merge({16'h0000, opb}, wb_dat_i, wb_sel_i));
				csfl_pkg::A_DIVHI: div_hi <= 16'(merge({16'h0000, div_hi}, wb_dat_i, wb_sel_i));
				csfl_pkg::A_IRQ_MASK: irq_mask <= wb_dat_i[csfl_pkg::EV_N-1:0];
				default: ;
			endcase
		end
	end

	// the op runs from the written ctrl word, so decode it from write data
	logic [3:0] wop;
	logic [15:0] waff;
	assign wop = wb_dat_i[csfl_pkg::C_OP_LSB +: 4];
	assign waff = {wb_dat_i[csfl_pkg::C_AFF_LSB +: 7], 9'h000};

	// affect mask per opcode, narrowed by software bits when nonzero
	function automatic logic [15:0] op_aff(input logic [3:0] o);
		case (o)
			csfl_pkg::OP_CMP: op_aff = 16'he400;
			csfl_pkg::OP_ADD, csfl_pkg::OP_SUB: op_aff = 16'hfc00;
			csfl_pkg::OP_SLA: op_aff = 16'he800 | 16'h1000;
			csfl_pkg::OP_SRL: op_aff = 16'hf000;
			csfl_pkg::OP_DIV: op_aff = 16'h0800;
			csfl_pkg::OP_ABS, csfl_pkg::OP_NEG: op_aff = 16'hf800;
			csfl_pkg::OP_XOP: op_aff = 16'h0200;
			csfl_pkg::OP_MOV: op_aff = 16'he400;
			default: op_aff = 16'h0000;
		endcase
	endfunction

	assign aff = op_aff(wop) & ((waff == 16'h0000) ? csfl_pkg::FLAG_MASK : waff);

	// operation must see the new ctrl: evaluate one cycle after the start write
	logic pend;
	logic [15:0] pend_aff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend <= 1'b0;
			pend_aff <= 16'h0000;
		end else if (ce_i) begin
			pend <= start;
			if (start)
				pend_aff <= aff;
		end
	end

	logic ctxsw_restore;
	assign ctxsw_restore = wr && wb_adr_i == csfl_pkg::A_SAVE && wb_dat_i[0];

	always_comb begin
		next_status = status_word;
		if (pend)
			next_status = (status_word & ~pend_aff) | (alu_fl & pend_aff);
		if (ctxsw_restore)
			next_status = saved[15:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_word <= csfl_pkg::ST_RESET;
			result <= 16'h0000;
		end else if (ce_i) begin
			status_word <= next_status;
			if (pend)
				result <= alu_res;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wp <= csfl_pkg::WP_RESET;
		else if (ctxsw_restore)
			wp <= saved[47:32];
		else if (wr && wb_adr_i == csfl_pkg::A_WP)
			wp <= {wb_dat_i[15:1], 1'b0};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			pc <= csfl_pkg::PC_RESET;
		else if (ctxsw_restore)
			pc <= saved[31:16];
		else if (wr && wb_adr_i == csfl_pkg::A_PC)
			pc <= {wb_dat_i[15:1], 1'b0};
		else if (fetch)
			pc <= 16'(pc + csfl_pkg::PC_STEP);
	end

	// register operand from workspace only
	// byte address of workspace register n is wp + 2n
	assign ws_addr = 16'(wp + {11'h000, ctrl[csfl_pkg::C_REG_LSB +: 4], 1'b0});

	// interrupt events
	assign ev[csfl_pkg::EV_DONE] = pend;
	assign ev[csfl_pkg::EV_OV] = pend && pend_aff[csfl_pkg::FL_OV] && alu_fl[csfl_pkg::FL_OV];
	assign ev[csfl_pkg::EV_XOP] = pend && pend_aff[csfl_pkg::FL_X] && alu_fl[csfl_pkg::FL_X];
	assign ev[csfl_pkg::EV_CTX] = ctxsw;

	// set wins over the read clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_st <= '0;
		else if (ce_i) begin
			if (rd && wb_adr_i == csfl_pkg::A_IRQ_ST)
				irq_st <= ev;
			else
				irq_st <= irq_st | ev;
		end
	end

	logic [csfl_pkg::EV_N-1:0] next_irq;
	assign next_irq = (ce_i ? ((rd && wb_adr_i == csfl_pkg::A_IRQ_ST) ? ev : (irq_st | ev))
		: irq_st) & irq_mask;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(next_irq);
	end

	// read mux, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (rd) begin
			case (wb_adr_i)
				csfl_pkg::A_CTRL: wb_dat_o <= ctrl;
				csfl_pkg::A_OPA: wb_dat_o <= {16'h0000, opa};
				csfl_pkg::A_OPB: wb_dat_o <= {16'h0000, opb};
				csfl_pkg::A_STATUS: wb_dat_o <= {16'h0000, status_word};
				csfl_pkg::A_RESULT: wb_dat_o <= {16'h0000, result};
				csfl_pkg::A_WP: wb_dat_o <= {16'h0000, wp};
				csfl_pkg::A_PC: wb_dat_o <= {16'h0000, pc};
				csfl_pkg::A_SAVE: wb_dat_o <= {16'h0000, saved[47:32]};
				csfl_pkg::A_IRQ_ST: wb_dat_o <= {28'h0000000, irq_st};
				csfl_pkg::A_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask};
				csfl_pkg::A_REGADDR: wb_dat_o <= {16'h0000, ws_addr};
				csfl_pkg::A_DIVHI: wb_dat_o <= {16'h0000, div_hi};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// reference values for the checks, formed apart from the flag datapath
	logic [16:0] ref_add;
	logic [16:0] ref_sub;
	logic [3:0] ref_last;
	logic [4:0] ref_cnt;
	logic [16:0] ref_mask;
	logic [16:0] ref_win;
	assign ref_add = {opb[15], opb} + {opa[15], opa};
	assign ref_sub = {opb[15], opb} - {opa[15], opa};
	assign ref_last = 4'(ctrl[csfl_pkg::C_SHCNT_LSB +: 4] - 4'h1);
	assign ref_cnt = {ctrl[csfl_pkg::C_SHCNT_LSB +: 4] == 4'h0, ctrl[csfl_pkg::C_SHCNT_LSB +: 4]};
	// bits that pass through the sign position, a zero shifted in last
	assign ref_mask = 17'h1ffff << (5'h10 - ref_cnt);
	assign ref_win = {opa, 1'b0} & ref_mask;

	a_eq_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
		pend && op == csfl_pkg::OP_CMP && pend_aff[csfl_pkg::FL_EQ] && ce_i
		|=> status_word[csfl_pkg::FL_EQ] == ($past(opa) == $past(opb) ||
		($past(ctrl[csfl_pkg::C_BYTE]) && $past(opa[15:8]) == $past(opb[15:8]))))
		else $error("equal flag wrong");
	a_neg_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
		pend && ce_i && (op == csfl_pkg::OP_NEG || op == csfl_pkg::OP_ABS)
		&& pend_aff[csfl_pkg::FL_OV]
		|=> status_word[csfl_pkg::FL_OV] == ($past(opa) == 16'h8000))
		else $error("negate overflow wrong");
	a_div_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
		pend && ce_i && op == csfl_pkg::OP_DIV && pend_aff[csfl_pkg::FL_OV]
		|=> status_word[csfl_pkg::FL_OV] == ($past(div_hi) >= $past(opa)))
		else $error("divide overflow wrong");
	a_pc_step: assert property (@(posedge clk_i) disable iff (rst_i)
		fetch && !ctxsw_restore |=> pc == 16'($past(pc) + 16'h0002))
		else $error("pc not stepped by two");
	a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && !ctxsw_restore |=> ((status_word ^ $past(status_word))
		& ~$past(pend_aff)) == 16'h0000)
		else $error("unaffected flag changed");
	a_xop_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_XOP && pend_aff[csfl_pkg::FL_X] && !ctxsw_restore
		|=> status_word[csfl_pkg::FL_X])
		else $error("xop flag not set");
	a_ws_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		ws_addr - wp < 16'h0020)
		else $error("register outside workspace");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held");
	a_add_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_ADD && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_C] |=> status_word[csfl_pkg::FL_C] == $past(opa > ~opb))
		else $error("add carry wrong");
	a_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_SUB && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_C] |=> status_word[csfl_pkg::FL_C] == $past(opb >= opa))
		else $error("subtract carry wrong");
	a_add_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_ADD && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_OV]
		|=> status_word[csfl_pkg::FL_OV] == $past(ref_add[16] != ref_add[15]))
		else $error("add overflow wrong");
	a_sub_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_SUB && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_OV]
		|=> status_word[csfl_pkg::FL_OV] == $past(ref_sub[16] != ref_sub[15]))
		else $error("subtract overflow wrong");
	a_srl_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_SRL && pend_aff[csfl_pkg::FL_C]
		|=> status_word[csfl_pkg::FL_C] == $past(opa[ref_last]))
		else $error("right shift carry wrong");
	a_sla_carry: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_SLA && pend_aff[csfl_pkg::FL_C]
		|=> status_word[csfl_pkg::FL_C] == $past(opa[~ref_last]))
		else $error("left shift carry wrong");
	a_sla_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_SLA && pend_aff[csfl_pkg::FL_OV]
		|=> status_word[csfl_pkg::FL_OV] == $past(ref_win != 17'h00000 && ref_win != ref_mask))
		else $error("left shift overflow wrong");
	a_byte_par: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && ctrl[csfl_pkg::C_BYTE] && pend_aff[csfl_pkg::FL_OP]
		&& (op == csfl_pkg::OP_MOV || op == csfl_pkg::OP_CMP)
		|=> status_word[csfl_pkg::FL_OP] == $past(^opa[15:8]))
		else $error("byte parity wrong");
	a_lgt_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_CMP && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_LGT] |=> status_word[csfl_pkg::FL_LGT] == $past(opa > opb))
		else $error("logical greater wrong");
	a_agt_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && pend && op == csfl_pkg::OP_CMP && !ctrl[csfl_pkg::C_BYTE]
		&& pend_aff[csfl_pkg::FL_AGT]
		|=> status_word[csfl_pkg::FL_AGT] == $past($signed(opa) > $signed(opb)))
		else $error("arithmetic greater wrong");
	a_ctx_restore: assert property (@(posedge clk_i) disable iff (rst_i)
		ctxsw_restore |=> wp == $past(saved[47:32]) && pc == $past(saved[31:16])
		&& status_word == $past(saved[15:0]))
		else $error("context not restored");
endmodule

// [sim/csfl_ws_mem.sv]
// workspace memory model: places the sixteen register words behind the pointer
// assumes byte addressing with two bytes a register word
module csfl_ws_mem (
	input wire logic [15:0] wp_i, // workspace base address
	input wire logic [3:0] reg_i, // register index
	input wire logic [15:0] wdat_i, // word to store
	input wire logic we_i, // store strobe
	output logic [15:0] addr_o, // byte address of register
	output logic [15:0] rdat_o // stored word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [16];
	assign addr_o = wp_i + {11'h000, reg_i, 1'b0};
	assign rdat_o = mem[reg_i];
	always @(posedge we_i) begin
		mem[reg_i] <= wdat_i;
	end
endmodule

// [sim/csfl_top_tb.sv]
// self-checking bench for the status flag and workspace context block
// assumes csfl_top acks each wishbone request one cycle after taking it
module csfl_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] rd;
	logic [31:0] q;
	logic [31:0] st;
	logic ack;
	logic irq;
	logic [15:0] wp_m = 16'h0000;
	logic [3:0] reg_m = 4'h0;
	logic [15:0] ra_m;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	always #20 clk_i = ~clk_i;
	csfl_top csfl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq));
	csfl_ws_mem csfl_ws_mem_inst (.wp_i(wp_m), .reg_i(reg_m), .wdat_i(16'h0000),
		.we_i(1'b0), .addr_o(ra_m), .rdat_o());
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// entered just after a rising edge; leaves just after one
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do @(posedge clk_i); while (ack !== 1'b1);
		// read data is taken at the edge that samples ack high
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic run(input logic [3:0] op, input logic [15:0] a, input logic [15:0] b,
		input logic [31:0] x);
		wb(1'b1, csfl_pkg::A_OPA, {16'h0000, a});
		wb(1'b1, csfl_pkg::A_OPB, {16'h0000, b});
		wb(1'b1, csfl_pkg::A_CTRL, x | {28'h0, op} | 32'h00010000);
		wb(1'b0, csfl_pkg::A_STATUS, 32'h0);
		st = q;
	endtask
	task automatic f(input string nm, input int b, input logic e);
		chk(nm, {31'h0, e}, {31'h0, st[b]});
	endtask
	task automatic t_reset;
		rdc("status", csfl_pkg::A_STATUS, 32'h0);
		rdc("wp", csfl_pkg::A_WP, 32'h0);
		rdc("unmapped", 8'h3c, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_cmp;
		run(csfl_pkg::OP_CMP, 16'h1234, 16'h1234, 32'h0);
		f("eq same", csfl_pkg::FL_EQ, 1'b1);
		run(csfl_pkg::OP_CMP, 16'h1234, 16'h1235, 32'h0);
		f("eq diff", csfl_pkg::FL_EQ, 1'b0);
		run(csfl_pkg::OP_CMP, 16'h12aa, 16'h12bb, 32'h10);
		f("eq byte", csfl_pkg::FL_EQ, 1'b1);
		// sign bit set: unsigned and signed orders disagree
		run(csfl_pkg::OP_CMP, 16'h8000, 16'h0001, 32'h0);
		f("lgt big", csfl_pkg::FL_LGT, 1'b1);
		f("agt neg", csfl_pkg::FL_AGT, 1'b0);
		run(csfl_pkg::OP_CMP, 16'h0001, 16'h8000, 32'h0);
		f("lgt swap", csfl_pkg::FL_LGT, 1'b0);
		f("agt swap", csfl_pkg::FL_AGT, 1'b1);
	endtask
	task automatic t_arith;
		run(csfl_pkg::OP_ADD, 16'h8000, 16'h8000, 32'h0);
		f("c add", csfl_pkg::FL_C, 1'b1);
		f("ov add", csfl_pkg::FL_OV, 1'b1);
		run(csfl_pkg::OP_ADD, 16'h4000, 16'h4000, 32'h0);
		f("c add2", csfl_pkg::FL_C, 1'b0);
		f("ov add2", csfl_pkg::FL_OV, 1'b1);
		run(csfl_pkg::OP_ADD, 16'h0001, 16'h0002, 32'h0);
		f("ov add3", csfl_pkg::FL_OV, 1'b0);
		run(csfl_pkg::OP_SUB, 16'h0001, 16'h8000, 32'h0);
		f("ov sub", csfl_pkg::FL_OV, 1'b1);
		f("c sub", csfl_pkg::FL_C, 1'b1);
		run(csfl_pkg::OP_SUB, 16'h0002, 16'h0001, 32'h0);
		f("ov sub2", csfl_pkg::FL_OV, 1'b0);
		f("c sub2", csfl_pkg::FL_C, 1'b0);
	endtask
	task automatic t_shift;
		run(csfl_pkg::OP_SRL, 16'h0001, 16'h0001, 32'h100);
		f("c srl", csfl_pkg::FL_C, 1'b1);
		run(csfl_pkg::OP_SRL, 16'h0002, 16'h0002, 32'h100);
		f("c srl2", csfl_pkg::FL_C, 1'b0);
		// count field zero means sixteen
		run(csfl_pkg::OP_SRL, 16'h8000, 16'h8000, 32'h0);
		f("c srl16", csfl_pkg::FL_C, 1'b1);
		run(csfl_pkg::OP_SLA, 16'h4000, 16'h4000, 32'h200);
		f("ov sla", csfl_pkg::FL_OV, 1'b1);
		f("c sla", csfl_pkg::FL_C, 1'b1);
		run(csfl_pkg::OP_SLA, 16'hc000, 16'hc000, 32'h100);
		f("ov sla1", csfl_pkg::FL_OV, 1'b0);
		run(csfl_pkg::OP_SLA, 16'hc000, 16'hc000, 32'h200);
		f("ov sla2", csfl_pkg::FL_OV, 1'b1);
	endtask
	task automatic t_ovsrc;
		wb(1'b1, csfl_pkg::A_DIVHI, 32'h5);
		run(csfl_pkg::OP_DIV, 16'h0005, 16'h0005, 32'h0);
		f("ov div", csfl_pkg::FL_OV, 1'b1);
		wb(1'b1, csfl_pkg::A_DIVHI, 32'h4);
		run(csfl_pkg::OP_DIV, 16'h0005, 16'h0005, 32'h0);
		f("ov div2", csfl_pkg::FL_OV, 1'b0);
		run(csfl_pkg::OP_ABS, 16'h8000, 16'h8000, 32'h0);
		f("ov abs", csfl_pkg::FL_OV, 1'b1);
		run(csfl_pkg::OP_ABS, 16'h8001, 16'h8001, 32'h0);
		f("ov abs2", csfl_pkg::FL_OV, 1'b0);
		run(csfl_pkg::OP_NEG, 16'h8000, 16'h8000, 32'h0);
		f("ov neg", csfl_pkg::FL_OV, 1'b1);
		run(csfl_pkg::OP_NEG, 16'h8001, 16'h8001, 32'h0);
		f("ov neg2", csfl_pkg::FL_OV, 1'b0);
		run(csfl_pkg::OP_MOV, 16'h0700, 16'h0700, 32'h10);
		f("op odd", csfl_pkg::FL_OP, 1'b1);
		run(csfl_pkg::OP_MOV, 16'h0300, 16'h0300, 32'h10);
		f("op even", csfl_pkg::FL_OP, 1'b0);
		run(csfl_pkg::OP_CMP, 16'h0005, 16'h0005, 32'h0);
		// affect mask with carry only: equal must survive
		run(csfl_pkg::OP_ADD, 16'h0001, 16'h0001, 32'h00800000);
		f("eq kept", csfl_pkg::FL_EQ, 1'b1);
	endtask
	task automatic t_irq;
		wb(1'b0, csfl_pkg::A_IRQ_ST, 32'h0);
		wb(1'b1, csfl_pkg::A_IRQ_MASK, 32'h2);
		run(csfl_pkg::OP_ADD, 16'h4000, 16'h4000, 32'h0);
		chk("irq up", 32'h1, {31'h0, irq});
		wb(1'b0, csfl_pkg::A_IRQ_ST, 32'h0);
		chk("irq ov bit", 32'h2, q & 32'h2);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wb(1'b1, csfl_pkg::A_IRQ_MASK, 32'h0);
		run(csfl_pkg::OP_XOP, 16'h0000, 16'h0000, 32'h0);
		f("x flag", csfl_pkg::FL_X, 1'b1);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdc("irq xop bit", csfl_pkg::A_IRQ_ST, 32'h5);
	endtask
	task automatic t_ctx;
		wb(1'b1, csfl_pkg::A_WP, 32'h0100);
		wb(1'b1, csfl_pkg::A_PC, 32'h0200);
		// equal set, overflow and extended op left by the irq scenario
		run(csfl_pkg::OP_CMP, 16'h0005, 16'h0005, 32'h0);
		wb(1'b1, csfl_pkg::A_CTRL, 32'h00020000);
		wb(1'b1, csfl_pkg::A_WP, 32'h0300);
		wb(1'b1, csfl_pkg::A_PC, 32'h0400);
		run(csfl_pkg::OP_CMP, 16'h0001, 16'h0002, 32'h0);
		wb(1'b1, csfl_pkg::A_CTRL, 32'h00040000);
		rdc("pc fetch", csfl_pkg::A_PC, 32'h0402);
		rdc("save wp", csfl_pkg::A_SAVE, 32'h0100);
		wb(1'b1, csfl_pkg::A_SAVE, 32'h1);
		rdc("wp back", csfl_pkg::A_WP, 32'h0100);
		rdc("pc back", csfl_pkg::A_PC, 32'h0200);
		rdc("st back", csfl_pkg::A_STATUS, 32'h00002a00);
	endtask
	task automatic t_ws;
		for (int i = 0; i < 16; i += 15) begin
			wp_m = 16'h0120;
			reg_m = i[3:0];
			wb(1'b1, csfl_pkg::A_WP, {16'h0, wp_m});
			wb(1'b1, csfl_pkg::A_CTRL, {16'h0, reg_m, 12'h000});
			rdc("reg addr", csfl_pkg::A_REGADDR, {16'h0, ra_m});
		end
	endtask
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			close_out;
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_cmp;
		t_arith;
		t_shift;
		t_ovsrc;
		t_irq;
		t_ctx;
		t_ws;
		close_out;
	end
endmodule
